// [design/swrg_top.sv]
// supply watchdog reset generator: two stretched active-low resets
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "swrg_cfg.svh"

module swrg_top #(
  parameter logic [23:0] T1_CYC = 24'(`SWRG_T1_CYC),
  parameter logic [23:0] T2_CYC = 24'(`SWRG_T2_CYC),
  parameter logic [23:0] WD0_CYC = 24'(`SWRG_WD0_CYC),
  parameter logic [23:0] WD1_CYC = 24'(`SWRG_WD1_CYC),
  parameter logic [23:0] WD2_CYC = 24'(`SWRG_WD2_CYC),
  parameter logic [23:0] WD3_CYC = 24'(`SWRG_WD3_CYC)
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic monitored_supply_low,
  input wire logic kick_input,
  input wire logic watchdog_disable,
  input wire logic period_sel_lsb,
  input wire logic period_sel_msb,
  output logic primary_reset_n,
  output logic aux_reset_n
);

  swrg_pkg::swrg_regs_s state_reg;
  swrg_pkg::swrg_regs_s state_next;

  // counters are 24 bits: enough for the longest stretch, 50 ms at 250 MHz.
  // a slower clock only needs smaller terminal counts; a faster one needs
  // wider counters, which this block does not provide.
  // clk_en low freezes every timer, so a gated clock stretches all delays.

  // ----------------------------------------------------------------------
  // two-stage synchroniser shift
  // ----------------------------------------------------------------------
  function automatic logic [1:0] sync_shift(
    input logic [1:0] stages,
    input logic pin
  );
    sync_shift = {stages[0], pin};
  endfunction : sync_shift

  // ----------------------------------------------------------------------
  // counter helpers shared by both stretch timers and the watchdog
  // ----------------------------------------------------------------------
  function automatic logic count_reached(
    input logic [23:0] count,
    input logic [23:0] limit
  );
    count_reached = (count >= limit);
  endfunction : count_reached

  // saturates instead of wrapping, so a count never falls back below its limit
  function automatic logic [23:0] count_step(
    input logic [23:0] count
  );
    if (count == 24'hFFFFFF)
    begin
      count_step = count;
    end
    else
    begin
      count_step = count + 24'h000001;
    end
  endfunction : count_step

  // primary reset is released in exactly these two states
  function automatic logic primary_released(
    input swrg_pkg::swrg_state_e st
  );
    case (st)
      swrg_pkg::SWRG_STRETCH2:
      begin
        primary_released = 1'b1;
      end
      swrg_pkg::SWRG_RUN:
      begin
        primary_released = 1'b1;
      end
      default:
      begin
        primary_released = 1'b0;
      end
    endcase
  endfunction : primary_released

  // ----------------------------------------------------------------------
  // watchdog period decode
  // ----------------------------------------------------------------------
  function automatic logic [23:0] wd_limit(
    input logic msb,
    input logic lsb
  );
    logic [1:0] sel;
    sel = {msb, lsb};
    if (sel == 2'h0)
    begin
      wd_limit = WD0_CYC;
    end
    else if (sel == 2'h1)
    begin
      wd_limit = WD1_CYC;
    end
    else if (sel == 2'h2)
    begin
      wd_limit = WD2_CYC;
    end
    else
    begin
      wd_limit = WD3_CYC;
    end
  endfunction : wd_limit

  // ----------------------------------------------------------------------
  // synchronised inputs
  // ----------------------------------------------------------------------
  logic supply_low;
  logic supply_low_any;
  logic kick_edge;
  logic [23:0] wd_term;

  assign supply_low = state_reg.monitored_supply_sync[1];
  // the raw pin is or-ed in so both outputs fall on the first edge that sees it;
  // this trades the synchroniser for an immediate response toward the safe state
  assign supply_low_any = monitored_supply_low | supply_low;
  assign kick_edge = state_reg.kick_sync[1] ^ state_reg.kick_last;
  assign wd_term = wd_limit(state_reg.sel_msb_sync[1], state_reg.sel_lsb_sync[1]);

  // ----------------------------------------------------------------------
  // stretch timers
  // ----------------------------------------------------------------------
  logic [23:0] delay_inc;
  logic stretch1_done;
  logic stretch2_done;

  assign delay_inc = count_step(state_reg.delay_cnt);
  assign stretch1_done = count_reached(state_reg.delay_cnt, T1_CYC);
  assign stretch2_done = count_reached(state_reg.delay_cnt, T2_CYC);

  // ----------------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------------
  // kick edges while the primary reset is low are ignored, and the mid-level
  // disable of the kick pin is modelled as its own input
  logic [23:0] wd_inc;
  logic watchdog_live;
  logic wd_service;
  logic wd_expired;

  assign wd_inc = count_step(state_reg.wd_cnt);
  assign watchdog_live = primary_released(state_reg.state);
  assign wd_service = kick_edge | state_reg.dis_sync[1];
  assign wd_expired = !wd_service && count_reached(wd_inc, wd_term);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;

    // synchronisers: every pin but reset and clk_en passes two flops; the supply pin is also read raw by the state machine
    state_next.monitored_supply_sync = sync_shift(state_reg.monitored_supply_sync, monitored_supply_low);
    state_next.kick_sync = sync_shift(state_reg.kick_sync, kick_input);
    state_next.kick_last = state_reg.kick_sync[1];
    state_next.dis_sync = sync_shift(state_reg.dis_sync, watchdog_disable);
    state_next.sel_lsb_sync = sync_shift(state_reg.sel_lsb_sync, period_sel_lsb);
    state_next.sel_msb_sync = sync_shift(state_reg.sel_msb_sync, period_sel_msb);

    // supply monitor and reset sequencer
    if (supply_low_any)
    begin
      // a low supply also cuts short any stretch already running
      state_next.state = swrg_pkg::SWRG_LOW_SUPPLY;
      state_next.delay_cnt = 24'h000000;
      state_next.rst1_n = 1'b0;
      state_next.rst2_n = 1'b0;
    end
    else
    begin
      case (state_reg.state)
        swrg_pkg::SWRG_LOW_SUPPLY:
        begin
          // supply has recovered: start the primary stretch
          state_next.state = swrg_pkg::SWRG_STRETCH1;
          state_next.delay_cnt = 24'h000001;
        end
        swrg_pkg::SWRG_STRETCH1:
        begin
          if (stretch1_done)
          begin
            // the watchdog count starts fresh as the primary reset rises
            state_next.state = swrg_pkg::SWRG_STRETCH2;
            state_next.delay_cnt = 24'h000001;
            state_next.rst1_n = 1'b1;
            state_next.wd_cnt = 24'h000000;
          end
          else
          begin
            state_next.delay_cnt = delay_inc;
          end
        end
        swrg_pkg::SWRG_STRETCH2:
        begin
          // an expiry below may still override this release
          if (stretch2_done)
          begin
            state_next.state = swrg_pkg::SWRG_RUN;
            state_next.rst2_n = 1'b1;
          end
          else
          begin
            state_next.delay_cnt = delay_inc;
          end
        end
        swrg_pkg::SWRG_RUN:
        begin
          // both resets released; only the watchdog below or a low supply above leaves this state
          state_next.state = swrg_pkg::SWRG_RUN;
        end
        default:
        begin
          state_next.state = swrg_pkg::SWRG_LOW_SUPPLY;
        end
      endcase

      // watchdog: runs only while the primary reset is released
      if (watchdog_live)
      begin
        if (wd_service)
        begin
          state_next.wd_cnt = 24'h000000;
        end
        else if (wd_expired)
        begin
          // expiry wins over a stretch2 release in the same cycle
          state_next.state = swrg_pkg::SWRG_STRETCH1;
          state_next.delay_cnt = 24'h000001;
          state_next.wd_cnt = 24'h000000;
          state_next.rst1_n = 1'b0;
          state_next.rst2_n = 1'b0;
        end
        else
        begin
          state_next.wd_cnt = wd_inc;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register; power-up behaves as a low supply
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      // the supply synchroniser starts out reporting a low supply, so both
      // outputs hold low until the pin has been seen low on two edges
      state_reg.monitored_supply_sync <= 2'h3;
      // kick history resets low; an edge seen during the stretch is ignored
      state_reg.kick_sync <= 2'h0;
      state_reg.kick_last <= 1'b0;
      state_reg.dis_sync <= 2'h0;
      state_reg.sel_lsb_sync <= 2'h0;
      state_reg.sel_msb_sync <= 2'h0;
      state_reg.state <= swrg_pkg::SWRG_LOW_SUPPLY;
      state_reg.delay_cnt <= 24'h000000;
      state_reg.wd_cnt <= 24'h000000;
      state_reg.rst1_n <= 1'b0;
      state_reg.rst2_n <= 1'b0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs come straight from the state register
  // ----------------------------------------------------------------------
  assign primary_reset_n = state_reg.rst1_n;
  assign aux_reset_n = state_reg.rst2_n;

endmodule : swrg_top
`default_nettype wire

// [design/swrg_cfg.svh]
// timing constants for the supply watchdog reset generator
`ifndef SWRG_CFG_SVH
`define SWRG_CFG_SVH
// ----------------------------------------------------------------------
// clock and delays
// ----------------------------------------------------------------------
`define SWRG_CLK_KHZ 250000
`define SWRG_T1_MS 50
`define SWRG_T2_MS 10
// watchdog periods in microseconds: 0.75 ms, 1.5 ms, 12.5 ms, 25 ms
`define SWRG_WD0_US 750
`define SWRG_WD1_US 1500
`define SWRG_WD2_US 12500
`define SWRG_WD3_US 25000
`define SWRG_T1_CYC (`SWRG_T1_MS * `SWRG_CLK_KHZ)
`define SWRG_T2_CYC (`SWRG_T2_MS * `SWRG_CLK_KHZ)
// divide the clock first: the product of microseconds and kHz overflows 32 bits
`define SWRG_WD0_CYC (`SWRG_WD0_US * (`SWRG_CLK_KHZ / 1000))
`define SWRG_WD1_CYC (`SWRG_WD1_US * (`SWRG_CLK_KHZ / 1000))
`define SWRG_WD2_CYC (`SWRG_WD2_US * (`SWRG_CLK_KHZ / 1000))
`define SWRG_WD3_CYC (`SWRG_WD3_US * (`SWRG_CLK_KHZ / 1000))
`define SWRG_CNT_W 24
`endif

// [design/swrg_pkg.sv]
// types for the supply watchdog reset generator
package swrg_pkg;
  typedef enum logic [1:0] {
    SWRG_LOW_SUPPLY,
    SWRG_STRETCH1,
    SWRG_STRETCH2,
    SWRG_RUN
  } swrg_state_e;

  typedef struct packed {
    logic [1:0] monitored_supply_sync;
    logic [1:0] kick_sync;
    logic kick_last;
    logic [1:0] dis_sync;
    logic [1:0] sel_lsb_sync;
    logic [1:0] sel_msb_sync;
    swrg_state_e state;
    logic [23:0] delay_cnt;
    logic [23:0] wd_cnt;
    logic rst1_n;
    logic rst2_n;
  } swrg_regs_s;
endpackage : swrg_pkg

// [bench/swrg_monitor.sv]
// assertion checker on the reset generator ports
`timescale 1ns/100ps
`default_nettype none
module swrg_monitor (
  input wire logic mclk,
  input wire logic reset,
  input wire logic monitored_supply_low,
  input wire logic kick_input,
  input wire logic watchdog_disable,
  input wire logic primary_reset_n,
  input wire logic aux_reset_n
);
  logic [7:0] low_reg;
  logic [7:0] idle_reg;
  logic kick_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // idle restarts early on a raw kick edge, so its bounds carry the sync slack
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      low_reg <= 8'h00;
      idle_reg <= 8'h00;
      kick_reg <= 1'b0;
    end
    else
    begin
      kick_reg <= kick_input;
      low_reg <= primary_reset_n ? 8'h00 : low_reg + {7'h00, low_reg != 8'hFF};
      idle_reg <= (!primary_reset_n || watchdog_disable || kick_reg != kick_input) ?
        8'h00 : idle_reg + 8'h01;
    end
  end
  a_supply_drops_both: assert property (monitored_supply_low |=> !primary_reset_n && !aux_reset_n)
    else $error("resets not low after low supply");
  a_aux_with_primary: assert property ($fell(primary_reset_n) |-> !aux_reset_n)
    else $error("aux reset late");
  a_aux_held_after: assert property ($rose(primary_reset_n) |-> !aux_reset_n [*8])
    else $error("aux reset released early");
  a_aux_release_gap: assert property ($rose(aux_reset_n) |-> $past(primary_reset_n, 10))
    else $error("aux released too soon after primary");
  a_primary_stretch: assert property ($rose(primary_reset_n) |-> low_reg >= 8'h32)
    else $error("primary stretch too short");
  a_expiry_needs_idle: assert property ($fell(primary_reset_n) && !$past(monitored_supply_low) |-> idle_reg >= 8'h08)
    else $error("watchdog expired early");
  a_expiry_bound: assert property (primary_reset_n |-> idle_reg < 8'h28)
    else $error("watchdog failed to expire");
  a_disable_holds: assert property (watchdog_disable && $past(watchdog_disable, 3) && primary_reset_n && !monitored_supply_low |=> primary_reset_n)
    else $error("expiry while disabled");
endmodule : swrg_monitor
`default_nettype wire

// [bench/swrg_cpu_model.sv]
// processor stand-in that toggles the kick line
`timescale 1ns/100ps
`default_nettype none
module swrg_cpu_model (
  input wire logic mclk,
  input wire logic run,
  output logic kick_input
);
  logic [1:0] div_reg = 2'h0;
  logic kick_reg = 1'b0;
  assign kick_input = kick_reg;
  // every 4 cycles, well inside the shortest period
  always @(posedge mclk)
  begin
    div_reg <= div_reg + 2'h1;
    if (run && div_reg == 2'h3)
      kick_reg <= !kick_reg;
  end
endmodule : swrg_cpu_model
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the supply watchdog reset generator
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [23:0] T1_SIM = 24'h000032;
  localparam logic [23:0] T2_SIM = 24'h00000A;
  localparam logic [23:0] WD0_SIM = 24'h000008;
  localparam logic [23:0] WD1_SIM = 24'h00000C;
  localparam logic [23:0] WD2_SIM = 24'h000014;
  localparam logic [23:0] WD3_SIM = 24'h00001E;
  logic mclk = 1'b0;
  logic en = 1'b1;
  logic reset = 1'b1;
  logic sup = 1'b1;
  logic dis = 1'b0;
  logic run = 1'b1;
  logic [1:0] sel = 2'h0;
  wire logic kick;
  wire logic prim_n;
  wire logic aux_n;
  int n_errors = 0;
  int total_checks = 0;
  int n;
  int wd[4] = '{int'(WD0_SIM), int'(WD1_SIM), int'(WD2_SIM), int'(WD3_SIM)};
  initial forever #2 mclk = !mclk;
  swrg_top #(.T1_CYC(T1_SIM), .T2_CYC(T2_SIM), .WD0_CYC(WD0_SIM), .WD1_CYC(WD1_SIM),
    .WD2_CYC(WD2_SIM), .WD3_CYC(WD3_SIM)) swrg_top_inst (.mclk(mclk), .reset(reset),
    .clk_en(en), .monitored_supply_low(sup), .kick_input(kick), .watchdog_disable(dis),
    .period_sel_lsb(sel[0]), .period_sel_msb(sel[1]), .primary_reset_n(prim_n),
    .aux_reset_n(aux_n));
  swrg_cpu_model swrg_cpu_model_inst (.mclk(mclk), .run(run), .kick_input(kick));
  task chk(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi)
    begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask : chk
  task chk_lvl(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_lvl
  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // counts edges until the chosen output reaches lvl; a hang ends the run
  task wait_lvl(input logic lvl, input logic use_aux);
    n = 0;
    while ((use_aux ? aux_n : prim_n) !== lvl)
    begin
      @(posedge mclk);
      n++;
      if (n > 300)
      begin
        n_errors++;
        tally_and_finish();
      end
    end
  endtask : wait_lvl
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task test_power_up;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    sup <= 1'b0;
    wait_lvl(1'b1, 1'b0);
    chk(n, int'(T1_SIM), int'(T1_SIM) + 8);
    wait_lvl(1'b1, 1'b1);
    chk(n, int'(T2_SIM), int'(T2_SIM) + 2);
    repeat (100) @(posedge mclk);
    chk_lvl(prim_n, 1'b1);
    $display("power-up and kick done");
  endtask : test_power_up
  task test_disable;
    run <= 1'b0;
    dis <= 1'b1;
    repeat (100) @(posedge mclk);
    chk_lvl(prim_n, 1'b1);
    dis <= 1'b0;
    wait_lvl(1'b0, 1'b0);
    chk(n, int'(WD0_SIM), int'(WD0_SIM) + 6);
    $display("disable done");
  endtask : test_disable
  task test_periods;
    for (int i = 0; i < 4; i++)
    begin
      sel <= 2'(i);
      wait_lvl(1'b1, 1'b0);
      wait_lvl(1'b0, 1'b0);
      chk(n, wd[i] - 1, wd[i] + 3);
      chk_lvl(aux_n, 1'b0);
    end
    $display("periods done");
  endtask : test_periods
  // supply drops during a watchdog stretch and stays low past its end
  task test_supply_dip;
    repeat (20) @(posedge mclk);
    sup <= 1'b1;
    repeat (80) @(posedge mclk);
    chk_lvl(prim_n | aux_n, 1'b0);
    sup <= 1'b0;
    wait_lvl(1'b1, 1'b0);
    chk(n, int'(T1_SIM), int'(T1_SIM) + 8);
    $display("supply dip done");
  endtask : test_supply_dip
  // supply drops while running: both outputs fall on the next edge
  task test_supply_drop;
    run <= 1'b1;
    wait_lvl(1'b1, 1'b1);
    repeat (40) @(posedge mclk);
    chk_lvl(prim_n, 1'b1);
    sup <= 1'b1;
    repeat (2) @(posedge mclk);
    chk_lvl(prim_n, 1'b0);
    chk_lvl(aux_n, 1'b0);
    $display("supply drop done");
  endtask : test_supply_drop
  // 20 frozen cycles inside the stretch lengthen it by 20, so the remaining wait stays near T1_SIM
  task test_clk_en;
    sup <= 1'b0;
    repeat (5) @(posedge mclk);
    en <= 1'b0;
    repeat (20) @(posedge mclk);
    en <= 1'b1;
    wait_lvl(1'b1, 1'b0);
    chk(n, int'(T1_SIM) - 4, int'(T1_SIM));
    $display("clock enable done");
  endtask : test_clk_en
  initial
  begin
    test_power_up();
    test_disable();
    test_periods();
    test_supply_dip();
    test_supply_drop();
    test_clk_en();
    tally_and_finish();
  end
endmodule : tb
bind swrg_top swrg_monitor swrg_monitor_inst (.mclk(mclk), .reset(reset),
  .monitored_supply_low(monitored_supply_low), .kick_input(kick_input),
  .watchdog_disable(watchdog_disable), .primary_reset_n(primary_reset_n),
  .aux_reset_n(aux_reset_n));
`default_nettype wire
